// File: core/hdlc_fifo_status_pkg.sv
// Summary of operation
// - frames of three or fewer bytes get the too-short status code unless aborted
// - a lone byte between flags carries both opening and closing tags
// - two or three byte frames tag first as opening, last as closing
// - receive data sits in bits 0 to 7, bit 0 received first
// - opening tag at bit 8 marks the first byte of a packet
// - closing tag at bit 9 marks the last byte, valid or not
// - status bits 10 and 11 mean something only with the closing tag
// - status 00 valid, 01 bad crc, 10 short or odd bits, 11 abort
// - write-only transmit word at 84h: data bits 0 to 7, end mark bit 8
// - transmit queue holds 256 bytes; writes while full are dropped
// - each transmit byte goes out bit 0 first, bit 7 last
// - after a marked byte the transmitter sends crc then two flags
// - transmit done flag latches on marked byte or underrun, clears on read
// - transmit low level flag high while fill is below the threshold
// - receive high level flag high while fill is above the threshold
// - receive begin flag latches on an opening byte, clears on read
// - receive finish flag latches at every message end with at least one byte, clears on read
// - a flag interrupts only when its mask and the group mask are set
// - threshold codes 0 to 7 select 16, 48, ... 240 bytes
package hdlc_fifo_status_pkg;

  localparam logic [7:0]  TX_FIFO_ADDR    = 8'h84;
  localparam logic [7:0]  STATUS_ADDR     = 8'h86;
  localparam logic [7:0]  RX_FIFO_ADDR    = 8'h82;

  localparam int          TX_DEPTH        = 256;
  localparam int          RX_DEPTH        = 256;
  localparam logic [8:0]  TX_FULL_COUNT   = 9'h100;
  localparam logic [8:0]  RX_FULL_COUNT   = 9'h100;

  localparam int          ST_TX_DONE      = 0;
  localparam int          ST_TX_LOW       = 2;
  localparam int          ST_RX_HIGH      = 4;
  localparam int          ST_RX_BEGIN     = 5;
  localparam int          ST_RX_FINISH    = 6;

  localparam logic [1:0]  PKT_VALID       = 2'h0;
  localparam logic [1:0]  PKT_BAD_CRC     = 2'h1;
  localparam logic [1:0]  PKT_SHORT       = 2'h2;
  localparam logic [1:0]  PKT_ABORT       = 2'h3;
  localparam logic [2:0]  SHORT_MAX_LEN   = 3'h3;
  localparam logic [2:0]  LEN_SAT         = 3'h4;

  localparam logic [4:0]  THRESH_BASE     = 5'h10;
  localparam logic [15:0] FLAG_BYTE       = 16'h007e;
  localparam logic [15:0] ABORT_BYTE      = 16'h00fe;
  localparam logic [15:0] CRC_INIT        = 16'hffff;
  localparam logic [15:0] CRC_POLY        = 16'h8408;
  localparam logic [4:0]  BYTE_BITS       = 5'h08;
  localparam logic [4:0]  CRC_BITS        = 5'h10;
  localparam logic [2:0]  STUFF_RUN       = 3'h5;

  typedef enum logic [2:0] {
    PH_IDLE  = 3'b000,
    PH_DATA  = 3'b001,
    PH_CRC   = 3'b010,
    PH_CLOSE = 3'b011,
    PH_ABORT = 3'b100
  } tx_phase_e;

  typedef struct packed {
    logic [7:0]  addr;
    logic        rd;
    logic        wr;
    logic [15:0] wdata;
  } host_req_s;

  typedef struct packed {
    logic       valid;
    logic [7:0] data;
    logic       done;
    logic       crc_bad;
    logic       abort;
    logic       nonintegral;
  } rx_octet_s;

  typedef struct packed {
    logic [1:0] status;
    logic       closing_tag;
    logic       opening_tag;
    logic [7:0] data;
  } rx_entry_s;

  typedef struct packed {
    logic [15:0] rdata;
    logic        irq;
    logic        tx_bit;
    logic        tx_frame_done_flag;
    logic        rx_frame_begin_flag;
    logic        rx_frame_finish_flag;
    logic        tx_low_level_flag;
    logic        rx_high_level_flag;
    logic [7:0]  tx_wr_ptr;
    logic [7:0]  tx_rd_ptr;
    logic [8:0]  tx_cnt;
    logic [7:0]  rx_wr_ptr;
    logic [7:0]  rx_rd_ptr;
    logic [8:0]  rx_cnt;
    logic [7:0]  tx_low_hold;
    logic        pend_valid;
    logic [7:0]  pend_byte;
    logic        pend_first;
    logic [2:0]  rx_len;
    logic [15:0] shift;
    logic [4:0]  bit_left;
    tx_phase_e   phase;
    logic [2:0]  ones;
    logic [15:0] crc;
    logic        cur_last;
  } state_s;

endpackage

// File: core/hdlc_fifo_status_port.sv
`timescale 1ns/1ps
module hdlc_fifo_status_port (
  input  wire logic                           clk,                      // 125 MHz clock
  input  wire logic                           nrst,                     // async reset, low
  input  wire hdlc_fifo_status_pkg::host_req_s host_req,               // host access
  input  wire logic                           byte_wide_bus_select,     // 1 = 8-bit bus
  input  wire logic [2:0]                     tx_low_threshold_select,  // tx level code
  input  wire logic [2:0]                     rx_high_threshold_select, // rx level code
  input  wire logic [15:0]                    frame_status_mask,        // per-flag mask
  input  wire logic                           group_interrupt_mask,     // group mask
  input  wire hdlc_fifo_status_pkg::rx_octet_s rx_octet,               // receiver octets
  input  wire logic                           tx_bit_enable,            // link bit slot
  output logic [15:0]                         host_rdata,               // read data
  output logic                                hdlc_irq,                 // interrupt, high
  output logic                                tx_bit                    // serial tx bit
);
  import hdlc_fifo_status_pkg::*;

  state_s     s;
  state_s     next_s;
  logic [8:0] tx_mem [TX_DEPTH];
  logic [11:0] rx_mem [RX_DEPTH];
  logic       tx_we;
  logic [8:0] tx_wdata;
  logic       rx_we;
  rx_entry_s  rx_wentry;

  function automatic logic [8:0] threshold(input logic [2:0] sel);
    // code n gives 16 + 32 * n bytes
    return {1'b0, sel, THRESH_BASE};
  endfunction

  function automatic logic [15:0] crc_step(input logic [15:0] c, input logic b);
    logic [15:0] r;
    r = {1'b0, c[15:1]};
    if (c[0] ^ b) begin
      r = r ^ CRC_POLY;
    end
    return r;
  endfunction

  function automatic logic [15:0] status_word(input state_s st);
    logic [15:0] w;
    w = 16'h0000;
    w[ST_TX_DONE]   = st.tx_frame_done_flag;
    w[ST_TX_LOW]    = st.tx_low_level_flag;
    w[ST_RX_HIGH]   = st.rx_high_level_flag;
    w[ST_RX_BEGIN]  = st.rx_frame_begin_flag;
    w[ST_RX_FINISH] = st.rx_frame_finish_flag;
    return w;
  endfunction

  function automatic logic [15:0] lane_view(input logic [15:0] w, input logic bw,
                                            input logic hi);
    // byte mode returns one lane in the low byte
    if (!bw) begin
      return w;
    end else if (hi) begin
      return {8'h00, w[15:8]};
    end
    return {8'h00, w[7:0]};
  endfunction

  function automatic logic [8:0] count_step(input logic [8:0] c, input logic inc,
                                            input logic dec);
    return c + {8'h00, inc} - {8'h00, dec};
  endfunction

  function automatic logic flag_update(input logic f, input logic clr, input logic set);
    // set wins over a clear in the same cycle
    return (f & ~clr) | set;
  endfunction

  function automatic rx_entry_s rx_pack(input logic [1:0] code, input logic last,
                                        input logic first, input logic [7:0] b);
    rx_entry_s e;
    e.status      = code;
    e.closing_tag = last;
    e.opening_tag = first;
    e.data        = b;
    return e;
  endfunction

  function automatic logic [1:0] frame_code(input rx_octet_s o, input logic [2:0] len);
    // abort outranks short, short outranks crc
    if (o.abort) begin
      return PKT_ABORT;
    end else if (o.nonintegral || len <= SHORT_MAX_LEN) begin
      return PKT_SHORT;
    end else if (o.crc_bad) begin
      return PKT_BAD_CRC;
    end
    return PKT_VALID;
  endfunction

  always_comb begin
    logic        lane_hi;
    logic [7:0]  word_addr;
    logic        tx_pop;
    logic        rx_pop;
    logic        clr_flags;
    logic        set_tx_done;
    logic        set_begin;
    logic        set_finish;
    logic        stuff;
    rx_entry_s   head;
    logic [8:0]  tx_head;
    logic [15:0] sw;
    next_s      = s;
    lane_hi     = byte_wide_bus_select & host_req.addr[0];
    word_addr   = {host_req.addr[7:1], 1'b0};
    tx_pop      = 1'b0;
    rx_pop      = 1'b0;
    clr_flags   = 1'b0;
    set_tx_done = 1'b0;
    set_begin   = 1'b0;
    set_finish  = 1'b0;
    stuff       = 1'b0;
    sw          = 16'h0000;
    head        = '0;
    if (s.rx_cnt != 9'h000) begin
      head = rx_entry_s'(rx_mem[s.rx_rd_ptr]);
    end
    tx_head     = tx_mem[s.tx_rd_ptr];
    tx_we       = 1'b0;
    tx_wdata    = 9'h000;
    rx_we       = 1'b0;
    rx_wentry   = '0;

    // host reads
    if (host_req.rd) begin
      unique case (word_addr)
        RX_FIFO_ADDR: begin
          // low lane only peeks, high lane pops
          next_s.rdata = lane_view({4'h0, head}, byte_wide_bus_select, lane_hi);
          rx_pop = (s.rx_cnt != 9'h000) && (!byte_wide_bus_select || lane_hi);
        end
        STATUS_ADDR: begin
          sw = status_word(s);
          // value returned is the one before the clear
          next_s.rdata = lane_view(sw, byte_wide_bus_select, lane_hi);
          clr_flags = !lane_hi;
        end
        default: begin
          next_s.rdata = 16'h0000;
        end
      endcase
    end

    if (host_req.wr && word_addr == TX_FIFO_ADDR) begin
      if (byte_wide_bus_select && !lane_hi) begin
        next_s.tx_low_hold = host_req.wdata[7:0];
      end else begin
        if (byte_wide_bus_select) begin
          tx_wdata = {host_req.wdata[0], s.tx_low_hold};
        end else begin
          tx_wdata = host_req.wdata[8:0];
        end
        tx_we    = (s.tx_cnt != TX_FULL_COUNT);
      end
    end

    // transmit serialiser
    if (tx_bit_enable) begin
      stuff = (s.ones == STUFF_RUN) &&
              (s.phase == PH_DATA || s.phase == PH_CRC ||
               (s.phase == PH_CLOSE && s.bit_left == BYTE_BITS));
      if (stuff) begin
        next_s.tx_bit = 1'b0;
        next_s.ones   = 3'h0;
      end else begin
        next_s.tx_bit   = s.shift[0];
        next_s.shift    = {1'b0, s.shift[15:1]};
        next_s.bit_left = s.bit_left - 5'h01;
        if (s.phase == PH_DATA || s.phase == PH_CRC) begin
          if (s.shift[0]) begin
            next_s.ones = s.ones + 3'h1;
          end else begin
            next_s.ones = 3'h0;
          end
        end else begin
          next_s.ones = 3'h0;
        end
        if (s.phase == PH_DATA) begin
          next_s.crc = crc_step(s.crc, s.shift[0]);
        end
        if (s.bit_left == 5'h01) begin
          unique case (s.phase)
            PH_IDLE, PH_ABORT: begin
              if (s.tx_cnt != 9'h000) begin
                tx_pop          = 1'b1;
                next_s.shift    = {8'h00, tx_head[7:0]};
                next_s.cur_last = tx_head[8];
                next_s.crc      = CRC_INIT;
                next_s.phase    = PH_DATA;
              end else begin
                next_s.shift = FLAG_BYTE;
                next_s.phase = PH_IDLE;
              end
              next_s.bit_left = BYTE_BITS;
            end
            PH_DATA: begin
              if (s.cur_last) begin
                next_s.shift    = ~next_s.crc;
                next_s.bit_left = CRC_BITS;
                next_s.phase    = PH_CRC;
                set_tx_done     = 1'b1;
              end else if (s.tx_cnt != 9'h000) begin
                tx_pop          = 1'b1;
                next_s.shift    = {8'h00, tx_head[7:0]};
                next_s.cur_last = tx_head[8];
                next_s.bit_left = BYTE_BITS;
              end else begin
                next_s.shift    = ABORT_BYTE;
                next_s.bit_left = BYTE_BITS;
                next_s.phase    = PH_ABORT;
                set_tx_done     = 1'b1;
              end
            end
            PH_CRC: begin
              next_s.shift    = FLAG_BYTE;
              next_s.bit_left = BYTE_BITS;
              next_s.phase    = PH_CLOSE;
              if (s.shift[0]) begin
                next_s.ones = s.ones + 3'h1;
              end else begin
                next_s.ones = 3'h0;
              end
            end
            PH_CLOSE: begin
              next_s.shift    = FLAG_BYTE;
              next_s.bit_left = BYTE_BITS;
              next_s.phase    = PH_IDLE;
            end
          endcase
        end
      end
    end

    // receive tagging
    if (rx_octet.valid) begin
      if (s.pend_valid) begin
        rx_wentry = rx_pack(PKT_VALID, 1'b0, s.pend_first, s.pend_byte);
        rx_we     = 1'b1;
      end
      next_s.pend_valid = 1'b1;
      next_s.pend_byte  = rx_octet.data;
      next_s.pend_first = (s.rx_len == 3'h0);
      set_begin         = (s.rx_len == 3'h0);
      // length saturates, only short or not matters
      if (s.rx_len != LEN_SAT) begin
        next_s.rx_len = s.rx_len + 3'h1;
      end
    end else if (rx_octet.done) begin
      if (s.pend_valid) begin
        // last byte closes, lone byte also opens
        rx_wentry = rx_pack(frame_code(rx_octet, s.rx_len), 1'b1, s.pend_first, s.pend_byte);
        rx_we     = 1'b1;
        set_finish = 1'b1;
      end
      next_s.pend_valid = 1'b0;
      next_s.rx_len     = 3'h0;
    end
    // full queue drops the entry
    if (s.rx_cnt == RX_FULL_COUNT) begin
      rx_we = 1'b0;
    end

    // queue pointers, wrap at the depth
    if (tx_we) begin
      next_s.tx_wr_ptr = s.tx_wr_ptr + 8'h01;
    end
    if (tx_pop) begin
      next_s.tx_rd_ptr = s.tx_rd_ptr + 8'h01;
    end
    next_s.tx_cnt = count_step(s.tx_cnt, tx_we, tx_pop);
    if (rx_we) begin
      next_s.rx_wr_ptr = s.rx_wr_ptr + 8'h01;
    end
    if (rx_pop) begin
      next_s.rx_rd_ptr = s.rx_rd_ptr + 8'h01;
    end
    next_s.rx_cnt = count_step(s.rx_cnt, rx_we, rx_pop);

    next_s.tx_frame_done_flag   = flag_update(s.tx_frame_done_flag, clr_flags, set_tx_done);
    next_s.rx_frame_begin_flag  = flag_update(s.rx_frame_begin_flag, clr_flags, set_begin);
    next_s.rx_frame_finish_flag = flag_update(s.rx_frame_finish_flag, clr_flags, set_finish);

    // levels use the counts after this cycle's moves
    // transmit and receive levels
    next_s.tx_low_level_flag  = next_s.tx_cnt < threshold(tx_low_threshold_select);
    next_s.rx_high_level_flag = next_s.rx_cnt > threshold(rx_high_threshold_select);

    next_s.irq = group_interrupt_mask &
                 (|(status_word(next_s) & frame_status_mask));
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      s          <= '0;
      s.shift    <= FLAG_BYTE;
      s.bit_left <= BYTE_BITS;
      s.phase    <= PH_IDLE;
      s.crc      <= CRC_INIT;
      s.tx_low_level_flag <= 1'b1;
    end else begin
      s <= next_s;
    end
  end

  // queue storage has no reset; reads are gated by the counts
  always_ff @(posedge clk) begin
    if (tx_we) begin
      tx_mem[s.tx_wr_ptr] <= tx_wdata;
    end
    if (rx_we) begin
      rx_mem[s.rx_wr_ptr] <= rx_wentry;
    end
  end

  assign host_rdata = s.rdata;
  assign hdlc_irq   = s.irq;
  assign tx_bit     = s.tx_bit;

endmodule

// File: tb/hdlc_fifo_status_port_asserts.sv
`timescale 1ns/1ps
module hdlc_fifo_status_port_asserts (
  input wire logic                            clk,                  // clock
  input wire logic                            nrst,                 // reset, low
  input wire hdlc_fifo_status_pkg::host_req_s host_req,             // bus request
  input wire logic                            byte_wide_bus_select, // byte mode
  input wire logic [15:0]                     frame_status_mask,    // flag masks
  input wire logic                            group_interrupt_mask, // group mask
  input wire hdlc_fifo_status_pkg::rx_octet_s rx_octet,             // rx octets
  input wire logic                            tx_bit_enable,        // bit slot
  input wire logic [15:0]                     host_rdata,           // read data
  input wire logic                            hdlc_irq,             // interrupt
  input wire logic                            tx_bit                // serial out
);
  import hdlc_fifo_status_pkg::*;
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!nrst);
  logic rds;
  logic quiet;
  assign rds = host_req.rd && host_req.addr[7:1] == STATUS_ADDR[7:1] && !byte_wide_bus_select;
  assign quiet = !rx_octet.valid && !rx_octet.done;
  AST_IRQ_GROUP: assert property (!group_interrupt_mask |=> !hdlc_irq)
    else $error("irq raised with group mask clear");
  AST_IRQ_MASK: assert property (frame_status_mask == 16'h0000 |=> !hdlc_irq)
    else $error("irq raised with flag masks clear");
  AST_RD_HOLD: assert property (!host_req.rd |=> $stable(host_rdata))
    else $error("read data moved without a read");
  AST_RD_TOP: assert property (host_req.rd |=> host_rdata[15:12] == 4'h0)
    else $error("read data top nibble set");
  AST_ST_SPARE: assert property (rds |=>
    host_rdata[15:7] == 9'h000 && !host_rdata[3] && !host_rdata[1])
    else $error("status spare bits set");
  AST_TX_WO: assert property (host_req.rd && host_req.addr[7:1] == TX_FIFO_ADDR[7:1] |=>
    host_rdata == 16'h0000)
    else $error("tx word readable");
  AST_TXBIT: assert property (!tx_bit_enable [*2] |=> $stable(tx_bit))
    else $error("tx bit moved without a slot");
  AST_BEGIN_CLR: assert property (quiet [*3] ##1 (rds && quiet) ##1 quiet ##1 rds |=>
    !host_rdata[ST_RX_BEGIN])
    else $error("begin flag survived a read");
endmodule
bind hdlc_fifo_status_port hdlc_fifo_status_port_asserts chk (
  .clk(clk), .nrst(nrst), .host_req(host_req), .byte_wide_bus_select(byte_wide_bus_select),
  .frame_status_mask(frame_status_mask), .group_interrupt_mask(group_interrupt_mask),
  .rx_octet(rx_octet), .tx_bit_enable(tx_bit_enable), .host_rdata(host_rdata),
  .hdlc_irq(hdlc_irq), .tx_bit(tx_bit)
);

// File: tb/hdlc_fifo_status_port_tb.sv
`timescale 1ns/1ps
`define chk(nm, e, a) begin total_checks++; if ((a) !== (e)) begin n_fail++; \
  $display("mismatch %s exp %h got %h", nm, e, a); end end
module hdlc_fifo_status_port_tb;
  import hdlc_fifo_status_pkg::*;
  logic        clk = 1'b0;
  logic        nrst = 1'b0;
  logic        bws = 1'b0;
  logic [2:0]  tsel = 3'h0;
  logic [15:0] mask = 16'h0000;
  logic        gmask = 1'b0;
  rx_octet_s   rxo = '0;
  logic        txe = 1'b0;
  host_req_s   req;
  logic [15:0] rdata;
  logic        irq;
  logic        txb;
  int          n_fail = 0;
  int          total_checks = 0;
  integer      seed = 69;
  logic [15:0] d;
  logic [15:0] sh = 16'h0000;
  logic [15:0] ew [0:31];
  logic [2:0]  tq [0:6] = '{3'h0, 3'h0, 3'h4, 3'h4, 3'h2, 3'h1, 3'h0};
  int          k = 0;

  always #4 clk = ~clk;

  hdlc_fifo_status_port uut (
    .clk(clk), .nrst(nrst), .host_req(req), .byte_wide_bus_select(bws),
    .tx_low_threshold_select(tsel), .rx_high_threshold_select(3'h0),
    .frame_status_mask(mask), .group_interrupt_mask(gmask), .rx_octet(rxo),
    .tx_bit_enable(txe), .host_rdata(rdata), .hdlc_irq(irq), .tx_bit(txb)
  );
  hdlc_host_model host (.clk(clk), .bws(bws), .rdata(rdata), .req(req));

  // code priority, q = crc, abort, odd bits
  function automatic logic [1:0] code(input int n, input logic [2:0] q);
    if (q[1]) return PKT_ABORT;
    if (q[0] || n <= 3) return PKT_SHORT;
    return q[2] ? PKT_BAD_CRC : PKT_VALID;
  endfunction

  task automatic frame(input int n, input logic [2:0] q);
    logic [7:0] b;
    for (int i = 0; i < n; i++) begin
      b = 8'($random(seed));
      ew[i] = {4'h0, (i == n - 1) ? code(n, q) : 2'h0, i == n - 1, i == 0, b};
      @(posedge clk) rxo <= {1'b1, b, 4'h0};
      @(posedge clk) rxo <= '0;
    end
    @(posedge clk) rxo <= {1'b0, 8'h00, 1'b1, q};
    @(posedge clk) rxo <= '0;
    repeat (4) @(posedge clk);
    #1 `chk("irq", gmask & mask[ST_RX_FINISH], irq)
    host.rd(STATUS_ADDR, d);
    `chk("status", {9'h0, 2'b11, n > 16, 4'h4}, d)
    host.rd(STATUS_ADDR, d);
    `chk("status clr", {11'h0, n > 16, 4'h4}, d)
    `chk("irq off", 1'b0, irq)
    for (int i = 0; i < n; i++) begin
      host.rd(RX_FIFO_ADDR, d);
      `chk("rx word", ew[i], d & (ew[i][9] ? 16'hffff : 16'hf3ff))
      if (i == 0) begin
        host.rd(STATUS_ADDR, d);
        `chk("rx high", {11'h0, n - 1 > 16, 4'h4}, d)
      end
    end
  endtask

  task automatic tbit();
    @(posedge clk) txe <= 1'b1;
    @(posedge clk) txe <= 1'b0;
    @(posedge clk);
    #1 sh = {txb, sh[15:1]};
  endtask

  task automatic test_done();
    $display("checks %0d mismatches %0d", total_checks, n_fail);
    if (n_fail == 0 && total_checks > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask

  initial begin
    #200000;
    n_fail++;
    test_done();
  end

  initial begin
    repeat (3) @(posedge clk);
    nrst <= 1'b1;
    host.rd(STATUS_ADDR, d);
    `chk("status reset", 16'h0004, d)
    host.rd(RX_FIFO_ADDR, d);
    `chk("rx empty", 16'h0000, d)
    host.rd(8'h90, d);
    `chk("unmapped", 16'h0000, d)
    host.rd(TX_FIFO_ADDR, d);
    `chk("tx wo", 16'h0000, d)
    $display("test reset done");
    for (int i = 0; i < 7; i++) frame(i + 1, tq[i]);
    @(posedge clk) bws <= 1'b1;
    frame(17, 3'h0);
    @(posedge clk) bws <= 1'b0;
    for (int i = 0; i < 4; i++) frame(1 + {$random(seed)} % 20, 3'($random(seed)));
    $display("test rx done");
    @(posedge clk) mask <= 16'h0004;
    repeat (2) @(posedge clk);
    #1 `chk("irq group", 1'b0, irq)
    @(posedge clk) gmask <= 1'b1;
    repeat (2) @(posedge clk);
    #1 `chk("irq low", 1'b1, irq)
    @(posedge clk) mask <= 16'h0040;
    frame(2, 3'h0);
    @(posedge clk) mask <= 16'h0000;
    $display("test irq done");
    for (int i = 0; i < 16; i++) begin
      if (i == 15) begin
        @(posedge clk) bws <= 1'b1;
        host.wr(TX_FIFO_ADDR, 16'h0112);
        bws <= 1'b0;
      end else begin
        host.wr(TX_FIFO_ADDR, 16'h0012);
      end
      if (i >= 14) begin
        host.rd(STATUS_ADDR, d);
        `chk("tx low", {13'h0, i < 15, 2'h0}, d)
      end
    end
    for (int c = 0; c < 8; c++) begin
      @(posedge clk) tsel <= 3'(c);
      repeat (2) @(posedge clk);
      host.rd(STATUS_ADDR, d);
      `chk("tx thr", {13'h0, 16 < 16 + 32 * c, 2'h0}, d)
    end
    @(posedge clk) tsel <= 3'h0;
    while (sh !== 16'h127e && k < 64) begin
      tbit();
      k++;
    end
    `chk("tx first", 16'h127e, sh)
    repeat (200) tbit();
    host.rd(STATUS_ADDR, d);
    `chk("tx done", 16'h0005, d)
    host.rd(STATUS_ADDR, d);
    `chk("tx done clr", 16'h0004, d)
    $display("test tx done");
    test_done();
  end
endmodule

// File: tb/hdlc_host_model.sv
`timescale 1ns/1ps
module hdlc_host_model (
  input  wire logic                       clk,   // bus clock
  input  wire logic                       bws,   // byte mode
  input  wire logic [15:0]                rdata, // read data
  output hdlc_fifo_status_pkg::host_req_s req    // bus request
);
  import hdlc_fifo_status_pkg::*;
  initial req = '0;
  // byte mode reads low lane, then high lane
  task automatic rd(input logic [7:0] a, output logic [15:0] q);
    logic [7:0] lo;
    @(posedge clk) req <= {a, 2'b10, 16'h0000};
    if (bws) begin
      @(posedge clk) req <= {a | 8'h01, 2'b10, 16'h0000};
      #1 lo = rdata[7:0];
      @(posedge clk) req <= '0;
      #1 q = {rdata[7:0], lo};
    end else begin
      @(posedge clk) req <= '0;
      #1 q = rdata;
    end
  endtask
  // low lane first; callers mark last of two or more
  task automatic wr(input logic [7:0] a, input logic [15:0] w);
    @(posedge clk);
    if (bws) begin
      req <= {a, 2'b01, 8'h00, w[7:0]};
      @(posedge clk) req <= {a | 8'h01, 2'b01, 8'h00, w[15:8]};
    end else begin
      req <= {a, 2'b01, w};
    end
    @(posedge clk) req <= '0;
  endtask
endmodule
